// ---- pkg/prog_mem_pkg.sv ----
package prog_mem_pkg;
    // Program store geometry.
    localparam int ADDR_W = 14;
    localparam int WORD_W = 16;
    localparam int DEPTH = 16384;
    localparam logic [13:0] RESET_VECTOR = 14'h0000;
    localparam logic [5:0] LAST_PAGE = 6'h3F;

    // Unique identifier window inside the last page and its checksum.
    localparam logic [7:0] UID_FIRST = 8'hE8;
    localparam logic [7:0] UID_LAST = 8'hEF;
    localparam int UID_DATA_BYTES = 14;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [15:0] CRC_XOR_OUT = 16'h0000;

    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_PTR_LOW = 8'h00;
    localparam logic [7:0] OFS_PTR_HIGH = 8'h04;
    localparam logic [7:0] OFS_LATCH = 8'h08;
    localparam logic [7:0] OFS_MAP_CTRL = 8'h0C;
    localparam logic [7:0] OFS_LOAD = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // Field positions and reset values.
    localparam int MAP_EN_BIT = 0;
    localparam int STAT_BUSY_BIT = 8;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'h00;

    // Serial frame: one direction bit, the word address, then the data word.
    localparam logic [5:0] SER_ADDR_END = 6'd15;
    localparam logic [5:0] SER_FRAME_END = 6'd31;

    typedef enum logic [0:0] {TR_IDLE, TR_READ} tr_state_t;

    // Table read request from the core.
    typedef struct packed {
        logic req;
        logic last_page;
        logic ext_sector;
    } tbl_req_t;

    // All state of the block except the program store.
    typedef struct packed {
        logic [7:0] ptr_low;
        logic [5:0] ptr_high;
        logic [7:0] latch;
        logic map_en;
        tr_state_t tr_state;
        logic [13:0] tr_addr;
        logic tr_ext;
        logic [7:0] tbl_data;
        logic tbl_done;
        logic tbl_ext;
        logic ack;
        logic [31:0] rdata;
        logic [13:0] fetch_pc;
        logic [15:0] fetch_word;
        logic [2:0] ck_sync;
        logic [1:0] dt_sync;
        logic [5:0] ser_cnt;
        logic [30:0] ser_shift;
        logic [15:0] ser_out;
        logic ser_dout;
        logic ser_oe;
        logic pin_func_en;
    } state_t;
endpackage : prog_mem_pkg

// ---- rtl/prog_mem_table_read.sv ----
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
module prog_mem_table_read #(
    parameter logic [111:0] UID_BYTES = 112'h0123456789ABCDEF0123456789AB, // Arbitrary value.
    parameter bit DEBUG_VARIANT = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire prog_mem_pkg::tbl_req_t tbl_req_i,
    output logic [7:0] tbl_data_o,
    output logic tbl_done_o,
    output logic tbl_ext_o,
    input wire logic fetch_next_i,
    input wire logic fetch_jump_i,
    input wire logic [13:0] fetch_target_i,
    output logic [13:0] fetch_pc_o,
    output logic [15:0] fetch_word_o,
    input wire logic prog_mode_i,
    input wire logic prog_serial_clock_i,
    input wire logic prog_serial_data_i,
    output logic prog_serial_data_o,
    output logic prog_serial_data_oe_o,
    output logic pin_func_en_o
);
    prog_mem_pkg::state_t st_reg;
    prog_mem_pkg::state_t st_next;
    // Flip-flop storage; kept beside the state struct since its size is large.
    logic [15:0] mem [prog_mem_pkg::DEPTH];
    logic mem_we;
    logic [13:0] mem_waddr;
    logic [15:0] mem_wdata;
    logic [15:0] rd_word;
    logic wb_req;
    logic tr_taken;
    logic ck_rise;
    logic ser_read;

    // identifier checksum
    // Checksum over the identifier bytes, evaluated once at elaboration.
    function automatic logic [15:0] crc16(input logic [111:0] b);
        logic [15:0] c;
        c = prog_mem_pkg::CRC_INIT;
        for (int i = 0; i < prog_mem_pkg::UID_DATA_BYTES; i++) begin
            c = c ^ {b[i*8 +: 8], 8'h00};
            for (int j = 0; j < 8; j++) begin
                c = c[15] ? ((c << 1) ^ prog_mem_pkg::CRC_POLY) : (c << 1);
            end
        end
        return c ^ prog_mem_pkg::CRC_XOR_OUT;
    endfunction : crc16

    // fixed identifier
    // The identifier is a parameter, so no bus path can ever change it.
    localparam logic [15:0] UID_CRC = crc16(UID_BYTES);

    // identifier window
    // True when an address falls in the identifier window of the last page.
    function automatic logic in_uid_window(input logic [13:0] a);
        return (a[13:8] == prog_mem_pkg::LAST_PAGE) && (a[7:0] >= prog_mem_pkg::UID_FIRST)
            && (a[7:0] <= prog_mem_pkg::UID_LAST);
    endfunction : in_uid_window

    // Word seen by table reads and fetch, with the identifier overlay applied.
    function automatic logic [15:0] table_word(input logic [13:0] a, input logic map_en,
                                               input logic [15:0] raw);
        logic [2:0] k;
        k = 3'(a[7:0] - prog_mem_pkg::UID_FIRST);
        if (!(map_en && in_uid_window(a))) begin
            return raw;
        end
        if (k == 3'h7) begin
            return UID_CRC;
        end
        return {UID_BYTES[k*16+8 +: 8], UID_BYTES[k*16 +: 8]};
    endfunction : table_word

    assign wb_req = wb_cyc_i && wb_stb_i && !st_reg.ack;
    assign tr_taken = tbl_req_i.req && (st_reg.tr_state == prog_mem_pkg::TR_IDLE);
    assign ck_rise = st_reg.ck_sync[1] && !st_reg.ck_sync[2];
    // The direction bit moves up one place per serial bit, so it is found by the count.
    // Only meaningful once the address has been shifted in.
    assign ser_read = st_reg.ser_shift[5'(st_reg.ser_cnt - 6'h01)];
    assign rd_word = table_word(st_reg.tr_addr, st_reg.map_en, mem[st_reg.tr_addr]);

    // Next-state logic for the table path, bus slave, fetch and serial port.
    always_comb begin
        st_next = st_reg;
        mem_we = 1'b0;
        mem_waddr = {st_reg.ptr_high, st_reg.ptr_low};
        mem_wdata = wb_dat_i[15:0];
        st_next.tbl_done = 1'b0;
        st_next.ack = 1'b0;
        st_next.ck_sync = {st_reg.ck_sync[1:0], prog_serial_clock_i};
        st_next.dt_sync = {st_reg.dt_sync[0], prog_serial_data_i};
        st_next.pin_func_en = !DEBUG_VARIANT;

        // Register bus; an unmapped offset still acknowledges and reads zero.
        if (wb_req) begin
            st_next.ack = 1'b1;
            st_next.rdata = 32'h0000_0000;
            if (wb_we_i && wb_sel_i[0]) begin
                unique case (wb_adr_i)
                    prog_mem_pkg::OFS_PTR_LOW: st_next.ptr_low = wb_dat_i[7:0];
                    prog_mem_pkg::OFS_PTR_HIGH: st_next.ptr_high = wb_dat_i[5:0];
                    prog_mem_pkg::OFS_LATCH: st_next.latch = wb_dat_i[7:0];
                    prog_mem_pkg::OFS_MAP_CTRL: st_next.map_en = wb_dat_i[prog_mem_pkg::MAP_EN_BIT];
                    prog_mem_pkg::OFS_LOAD: mem_we = wb_sel_i[1];
                    default: ;
                endcase
            end else if (!wb_we_i) begin
                unique case (wb_adr_i)
                    prog_mem_pkg::OFS_PTR_LOW: st_next.rdata[7:0] = st_reg.ptr_low;
                    prog_mem_pkg::OFS_PTR_HIGH: st_next.rdata[5:0] = st_reg.ptr_high;
                    prog_mem_pkg::OFS_LATCH: st_next.rdata[7:0] = st_reg.latch;
                    prog_mem_pkg::OFS_MAP_CTRL: st_next.rdata[0] = st_reg.map_en;
                    prog_mem_pkg::OFS_STATUS: begin
                        st_next.rdata[7:0] = st_reg.tbl_data;
                        st_next.rdata[prog_mem_pkg::STAT_BUSY_BIT] =
                            (st_reg.tr_state == prog_mem_pkg::TR_READ);
                    end
                    default: ;
                endcase
            end
        end

        // Table read: first cycle forms the address, second cycle transfers.
        unique case (st_reg.tr_state)
            prog_mem_pkg::TR_IDLE: begin
                if (tr_taken) begin
                    if (tbl_req_i.last_page) begin
                        st_next.tr_addr = {prog_mem_pkg::LAST_PAGE, st_reg.ptr_low};
                    end else begin
                        st_next.tr_addr = {st_reg.ptr_high, st_reg.ptr_low};
                    end
                    st_next.tr_ext = tbl_req_i.ext_sector;
                    st_next.tr_state = prog_mem_pkg::TR_READ;
                end
            end
            prog_mem_pkg::TR_READ: begin
                st_next.tbl_data = rd_word[7:0];
                st_next.latch = rd_word[15:8];
                st_next.tbl_ext = st_reg.tr_ext;
                st_next.tbl_done = 1'b1;
                st_next.tr_state = prog_mem_pkg::TR_IDLE;
            end
        endcase

        // Instruction fetch from the program counter.
        if (fetch_jump_i) begin
            st_next.fetch_pc = fetch_target_i;
        end else if (fetch_next_i) begin
            st_next.fetch_pc = 14'(st_reg.fetch_pc + 14'h0001);
        end
        st_next.fetch_word = table_word(st_next.fetch_pc, st_reg.map_en, mem[st_next.fetch_pc]);

        // Serial programming; a frame is bounded by the programming mode level.
        if (!prog_mode_i) begin
            st_next.ser_cnt = 6'h00;
            st_next.ser_oe = 1'b0;
            st_next.ser_dout = 1'b0;
        end else if (ck_rise && (st_reg.ser_cnt != prog_mem_pkg::SER_FRAME_END)) begin
            st_next.ser_cnt = 6'(st_reg.ser_cnt + 6'h01);
            st_next.ser_shift = {st_reg.ser_shift[29:0], st_reg.dt_sync[1]};
            if (st_next.ser_cnt == prog_mem_pkg::SER_ADDR_END && st_next.ser_shift[14]) begin
                st_next.ser_out = mem[st_next.ser_shift[13:0]];
            end
            if (st_reg.ser_cnt >= prog_mem_pkg::SER_ADDR_END && ser_read) begin
                st_next.ser_out = {st_reg.ser_out[14:0], 1'b0};
            end
            // The pin is released on the last bit so the programmer may drive again.
            st_next.ser_oe = ser_read && (st_reg.ser_cnt >= prog_mem_pkg::SER_ADDR_END)
                && (st_next.ser_cnt != prog_mem_pkg::SER_FRAME_END);
            if (st_next.ser_cnt == prog_mem_pkg::SER_ADDR_END) begin
                st_next.ser_oe = st_next.ser_shift[14];
            end
            st_next.ser_dout = st_next.ser_out[15];
            if (st_next.ser_cnt == prog_mem_pkg::SER_FRAME_END && !st_next.ser_shift[30]) begin
                mem_we = 1'b1;
                mem_waddr = st_next.ser_shift[29:16];
                mem_wdata = st_next.ser_shift[15:0];
            end
        end
        if (!ce_i) begin
            mem_we = 1'b0;
        end
    end

    // State register; the clock enable freezes everything.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.ptr_low <= prog_mem_pkg::PTR_RST;
            st_reg.latch <= prog_mem_pkg::LATCH_RST;
            st_reg.tr_state <= prog_mem_pkg::TR_IDLE;
            st_reg.fetch_pc <= prog_mem_pkg::RESET_VECTOR;
            st_reg.pin_func_en <= !DEBUG_VARIANT;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    assign wb_dat_o = st_reg.rdata;
    assign wb_ack_o = st_reg.ack;
    assign tbl_data_o = st_reg.tbl_data;
    assign tbl_done_o = st_reg.tbl_done;
    assign tbl_ext_o = st_reg.tbl_ext;
    assign fetch_pc_o = st_reg.fetch_pc;
    assign fetch_word_o = st_reg.fetch_word;
    assign prog_serial_data_o = st_reg.ser_dout;
    assign prog_serial_data_oe_o = st_reg.ser_oe;
    assign pin_func_en_o = st_reg.pin_func_en;

    property p_reset_vector;
        @(posedge clk_i) $past(rst_i) && !rst_i |-> fetch_pc_o == 14'h0000;
    endproperty
    a_reset_vector: assert property (p_reset_vector) else $error("pc not zero after reset");

    property p_two_cycles;
        @(posedge clk_i) disable iff (rst_i || !ce_i)
            tr_taken ##1 ce_i |=> tbl_done_o;
    endproperty
    a_two_cycles: assert property (p_two_cycles) else $error("table read not done in two");

    property p_low_byte;
        @(posedge clk_i) disable iff (rst_i)
            (st_reg.tr_state == prog_mem_pkg::TR_READ) && ce_i |=> tbl_data_o == $past(rd_word[7:0]);
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte not transferred");

    property p_high_byte;
        @(posedge clk_i) disable iff (rst_i)
            (st_reg.tr_state == prog_mem_pkg::TR_READ) && ce_i |=> st_reg.latch == $past(rd_word[15:8]);
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("high byte not latched");

    property p_full_addr;
        @(posedge clk_i) disable iff (rst_i || !ce_i)
            tr_taken && !tbl_req_i.last_page |=>
                st_reg.tr_addr == $past({st_reg.ptr_high, st_reg.ptr_low});
    endproperty
    a_full_addr: assert property (p_full_addr) else $error("pointer address wrong");

    property p_last_page;
        @(posedge clk_i) disable iff (rst_i || !ce_i)
            tr_taken && tbl_req_i.last_page |=> st_reg.tr_addr[13:8] == 6'h3F;
    endproperty
    a_last_page: assert property (p_last_page) else $error("last page not addressed");

    property p_map_off;
        @(posedge clk_i) disable iff (rst_i)
            !st_reg.map_en |-> rd_word == mem[st_reg.tr_addr];
    endproperty
    a_map_off: assert property (p_map_off) else $error("overlay seen while disabled");

    property p_crc_word;
        @(posedge clk_i) disable iff (rst_i)
            st_reg.map_en && st_reg.tr_addr == 14'h3FEF |-> rd_word == UID_CRC;
    endproperty
    a_crc_word: assert property (p_crc_word) else $error("checksum word wrong");

    property p_sector;
        @(posedge clk_i) disable iff (rst_i)
            tbl_done_o |-> tbl_ext_o == $past(st_reg.tr_ext, 1);
    endproperty
    a_sector: assert property (p_sector) else $error("sector form lost");

    property p_latch_write;
        @(posedge clk_i) disable iff (rst_i || !ce_i)
            wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h08
                && st_reg.tr_state == prog_mem_pkg::TR_IDLE |=> st_reg.latch == $past(wb_dat_i[7:0]);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch write lost");

    property p_pin_func;
        @(posedge clk_i) disable iff (rst_i)
            pin_func_en_o == !DEBUG_VARIANT;
    endproperty
    a_pin_func: assert property (p_pin_func) else $error("debug pin sharing wrong");

    property p_ser_idle;
        @(posedge clk_i) disable iff (rst_i)
            !prog_mode_i && ce_i |=> !prog_serial_data_oe_o;
    endproperty
    a_ser_idle: assert property (p_ser_idle) else $error("data pin driven outside frame");

    property p_ser_end;
        @(posedge clk_i) disable iff (rst_i)
            st_reg.ser_cnt == prog_mem_pkg::SER_FRAME_END |-> !prog_serial_data_oe_o;
    endproperty
    a_ser_end: assert property (p_ser_end) else $error("data pin held after frame");

    property p_outside_window;
        @(posedge clk_i) disable iff (rst_i)
            !in_uid_window(st_reg.tr_addr) |-> rd_word == mem[st_reg.tr_addr];
    endproperty
    a_outside_window: assert property (p_outside_window) else $error("overlay outside window");
endmodule : prog_mem_table_read

// ---- tb/cpu_core_model.sv ----
`timescale 1ns/1ns
// Core side of the table-read port: one request at a time, result taken on done.
module cpu_core_model (
    input wire logic clk_i,
    input wire logic done_i,
    input wire logic [7:0] data_i,
    output prog_mem_pkg::tbl_req_t req_o
);
    initial begin
        req_o = '0;
    end

    // Request stands for one cycle, then stays low while the engine is busy.
    task automatic table_read(input logic last, input logic ext,
            output logic [7:0] data, output int cyc);
        @(posedge clk_i);
        req_o <= '{req: 1'b1, last_page: last, ext_sector: ext};
        @(posedge clk_i);
        req_o <= '0;
        cyc = 0;
        do begin
            @(posedge clk_i);
            cyc++;
        end while (done_i !== 1'b1 && cyc < 20);
        data = data_i;
    endtask : table_read
endmodule : cpu_core_model

// ---- tb/tb_prog_mem_table_read.sv ----
`timescale 1ns/1ns
module tb_prog_mem_table_read;
    localparam logic [111:0] UID_VAL = 112'h5E13A7C2904B6D18F3E07A2C9D41; // Arbitrary value.
    logic clk_i, rst_i, cyc, we, jump, nxt;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [13:0] target;
    logic pmode, sclk, sdat;
    wire logic sdo, soe;
    logic [31:0] lfsr = 32'h0000720A;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o, tbl_done_o, tbl_ext_o, pin_func_en_o;
    wire logic [7:0] tbl_data_o;
    wire logic [13:0] fetch_pc_o;
    wire logic [15:0] fetch_word_o;
    wire prog_mem_pkg::tbl_req_t tbl_req;
    int fails, n_checks, a;
    int mem[int];

    // The bench is the only driver of the programming pins.
    prog_mem_table_read #(.UID_BYTES(UID_VAL), .DEBUG_VARIANT(1'b0)) u_prog_mem_table_read (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .tbl_req_i(tbl_req), .tbl_data_o(tbl_data_o),
        .tbl_done_o(tbl_done_o), .tbl_ext_o(tbl_ext_o), .fetch_next_i(nxt),
        .fetch_jump_i(jump), .fetch_target_i(target), .fetch_pc_o(fetch_pc_o),
        .fetch_word_o(fetch_word_o), .prog_mode_i(pmode), .prog_serial_clock_i(sclk),
        .prog_serial_data_i(sdat), .prog_serial_data_o(sdo), .prog_serial_data_oe_o(soe),
        .pin_func_en_o(pin_func_en_o));

    cpu_core_model u_cpu_core_model (.clk_i(clk_i), .done_i(tbl_done_o),
        .data_i(tbl_data_o), .req_o(tbl_req));

    // Free-running 50 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    // Bitwise CRC, MSB first, over identifier bytes 0 to 13.
    function automatic int crc16();
        int c;
        c = 0;
        for (int i = 0; i < 14; i++) begin
            c = c ^ (int'(UID_VAL[8*i +: 8]) << 8);
            for (int b = 0; b < 8; b++) begin
                c = (c & 32'h00008000) ? ((c << 1) ^ 32'h00001021) : (c << 1);
                c = c & 32'h0000FFFF;
            end
        end
        return c;
    endfunction : crc16

    // Reference word at a table address, identifier overlay included.
    function automatic int exp_word(int adr_w, bit map);
        int k;
        k = adr_w - 32'h00003FE8;
        if (map && k >= 0 && k < 7) return int'(UID_VAL[16*k +: 16]);
        if (map && k == 7) return crc16();
        return mem[adr_w];
    endfunction : exp_word

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("Checks made %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // Classic single bus cycle; read data is taken at the edge that sees ack.
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        cyc <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            fails++;
            wrap_up();
        end
    endtask : wb

    // One serial bit: data set up for four clocks, then a clock pulse of four.
    task automatic ser_bit(input logic b);
        @(posedge clk_i);
        sdat <= b;
        repeat (4) @(posedge clk_i);
        sclk <= 1'b1;
        repeat (4) @(posedge clk_i);
        sclk <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : ser_bit

    task automatic load(input int ad, input int w);
        wb(1'b1, prog_mem_pkg::OFS_PTR_LOW, ad & 32'h000000FF, rdat);
        wb(1'b1, prog_mem_pkg::OFS_PTR_HIGH, (ad >> 8) & 32'h0000003F, rdat);
        wb(1'b1, prog_mem_pkg::OFS_LOAD, w & 32'h0000FFFF, rdat);
        mem[ad] = w & 32'h0000FFFF;
    endtask : load

    // One table read through the core model, compared with the reference.
    task automatic tread(input int ad, input logic last, input logic ext, input bit map);
        logic [7:0] d;
        int c, w;
        w = exp_word(ad, map);
        u_cpu_core_model.table_read(last, ext, d, c);
        check("table cycles", c, 2); // Two cycles.
        if (c >= 20) wrap_up();
        check("table low byte", d, w & 32'h000000FF); // Low byte out.
        check("ext echo", tbl_ext_o, ext); // Form echoed.
        wb(1'b0, prog_mem_pkg::OFS_LATCH, 32'h0, rdat);
        check("latch", rdat, (w >> 8) & 32'h000000FF); // High byte held.
        wb(1'b0, prog_mem_pkg::OFS_STATUS, 32'h0, rdat);
        check("status", rdat, w & 32'h000000FF); // Low byte kept, idle.
    endtask : tread

    // Main sequence.
    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0;
        jump = 1'b0;
        nxt = 1'b0;
        target = 14'h0;
        pmode = 1'b0;
        sclk = 1'b0;
        sdat = 1'b0;
        fails = 0;
        n_checks = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("reset pc", fetch_pc_o, 14'h0000); // Start at zero.
        check("pin functions", pin_func_en_o, 1'b1); // Full part keeps them.
        wb(1'b0, prog_mem_pkg::OFS_LATCH, 32'h0, rdat);
        check("latch reset", rdat, prog_mem_pkg::LATCH_RST); // Reset value.
        wb(1'b0, prog_mem_pkg::OFS_MAP_CTRL, 32'h0, rdat);
        check("map reset", rdat, 32'h0); // Mapping off.
        wb(1'b0, 8'h40, 32'h0, rdat);
        check("unmapped read", rdat, 32'h0); // Empty place.
        wb(1'b1, prog_mem_pkg::OFS_LATCH, 32'h000000A5, rdat);
        wb(1'b0, prog_mem_pkg::OFS_LATCH, 32'h0, rdat);
        check("latch rw", rdat, 32'h000000A5); // Save and restore.
        $display("Test registers done");
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 0 : (i == 1) ? 32'h00003FFF : (rnd() & 32'h00003FFF);
            load(a, rnd());
            tread(a, 1'b0, i[0], 1'b0); // Any word.
        end
        $display("Test full pointer done");
        for (int i = 0; i < 4; i++) begin
            a = 32'h00003F00 | (rnd() & 32'h000000FF);
            load(a, rnd());
            wb(1'b1, prog_mem_pkg::OFS_PTR_HIGH, 32'h00000012, rdat);
            tread(a, 1'b1, i[0], 1'b0); // High pointer ignored.
        end
        $display("Test last page done");
        for (int m = 0; m < 2; m++) begin
            wb(1'b1, prog_mem_pkg::OFS_MAP_CTRL, m, rdat);
            for (int k = 0; k < 8; k++) begin
                load(32'h00003FE8 + k, rnd());
                tread(32'h00003FE8 + k, k[0], 1'b0, m[0]); // Overlay.
            end
        end
        $display("Test identifier done");
        // Serial read frame of word 0: direction, 14 address bits, then 16 data bits.
        @(posedge clk_i);
        pmode <= 1'b1;
        ser_bit(1'b1);
        for (int j = 0; j < 14; j++) ser_bit(1'b0);
        for (int j = 15; j >= 0; j--) begin
            check("serial oe", soe, 1'b1); // Device drives.
            check("serial bit", sdo, (mem[0] >> j) & 1); // MSB first.
            ser_bit(1'b0);
        end
        check("serial release", soe, 1'b0); // Pin freed.
        @(posedge clk_i);
        pmode <= 1'b0;
        $display("Test serial done");
        for (int i = 0; i < 2; i++) begin
            a = (i == 0) ? 0 : 32'h00003FFF;
            @(posedge clk_i);
            jump <= 1'b1;
            target <= a[13:0];
            @(posedge clk_i);
            jump <= 1'b0;
            nxt <= 1'b1;
            @(posedge clk_i);
            nxt <= 1'b0;
            check("fetch pc", fetch_pc_o, a); // Jump target.
            check("fetch word", fetch_word_o, mem[a]); // Word fetched.
            @(posedge clk_i);
            check("fetch next", fetch_pc_o, (a + 1) & 32'h00003FFF); // 14-bit wrap.
        end
        $display("Test fetch done");
        wrap_up();
    end
endmodule : tb_prog_mem_table_read
